// file: include/cyc_timer_pkg.sv
`default_nettype none
package cyc_timer_pkg;

  localparam int unsigned CLK_HZ    = 200_000_000;
  localparam int unsigned US_PER_S  = 1_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / US_PER_S;

  localparam logic [6:0]  CTRL_REG_ADDR  = 7'h06;
  localparam logic [15:0] CTRL_REG_RST   = 16'h0000;
  // Reserved bits 12 and 3 are never stored
  localparam logic [15:0] CTRL_REG_WMASK = 16'heff7;

  // Times in microseconds
  localparam int unsigned ON_T1_US  = 100;
  localparam int unsigned ON_T2_US  = 300;
  localparam int unsigned ON_T3_US  = 1_000;
  localparam int unsigned ON_T4_US  = 10_000;
  localparam int unsigned ON_T5_US  = 20_000;
  localparam int unsigned PER_T0_US = 10_000;
  localparam int unsigned PER_T1_US = 20_000;
  localparam int unsigned PER_T2_US = 50_000;
  localparam int unsigned PER_T3_US = 100_000;
  localparam int unsigned PER_T4_US = 200_000;
  localparam int unsigned PER_T5_US = 500_000;
  localparam int unsigned PER_T6_US = 1_000_000;
  localparam int unsigned PER_T7_US = 2_000_000;
  localparam int unsigned FILT_US   = 16;

  localparam int unsigned FILT_CYC = FILT_US * CYC_PER_US;

  localparam logic [2:0] ON_OFF_LOW  = 3'h0;
  localparam logic [2:0] ON_OFF_HIGH = 3'h6;
  localparam logic [1:0] WAKE_NONE   = 2'h0;
  localparam logic [1:0] WAKE_FIRST  = 2'h1;
  localparam logic [1:0] WAKE_SECOND = 2'h2;
  localparam logic [2:0] FILT_CYC_FIRST  = 3'h2;
  localparam logic [2:0] FILT_CYC_SECOND = 3'h3;

  typedef struct packed {
    logic [2:0] second_on_time_sel;
    logic       rsvd_hi;
    logic [2:0] second_period_sel;
    logic [1:0] cyclic_wake_sel;
    logic [2:0] first_on_time_sel;
    logic       rsvd_lo;
    logic [2:0] first_period_sel;
  } timer_ctrl_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

endpackage
`default_nettype wire

// file: verilog/dual_cyclic_timer_control.sv
`timescale 1ns/1ps
`default_nettype none
module dual_cyclic_timer_control
  import cyc_timer_pkg::*;
#(
  parameter int unsigned US_CYCLES = CYC_PER_US
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        soft_rst,
  input  wire logic        restart_entry,
  input  wire reg_req_t    req,
  output logic [15:0]      rdata,
  input  wire logic [1:0]  sense_clear,
  input  wire logic [2:0]  wake_filter_sel,
  input  wire logic        wake_in,
  output logic [1:0]       timer_out,
  output logic [1:0]       period_start,
  output logic [1:0]       cyc_wake_event,
  output logic             wake_detected
);

  timer_ctrl_t ctrl_q;
  timer_ctrl_t ctrl_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic [2:0]  on_sel   [2];
  logic [2:0]  per_sel  [2];
  logic        on_end   [2];

  assign on_sel[0]  = ctrl_q.first_on_time_sel;
  assign on_sel[1]  = ctrl_q.second_on_time_sel;
  assign per_sel[0] = ctrl_q.first_period_sel;
  assign per_sel[1] = ctrl_q.second_period_sel;

  function automatic logic [21:0] on_us(input logic [2:0] code);
    case (code)
      3'h1:    on_us = 22'(ON_T1_US);
      3'h2:    on_us = 22'(ON_T2_US);
      3'h3:    on_us = 22'(ON_T3_US);
      3'h4:    on_us = 22'(ON_T4_US);
      3'h5:    on_us = 22'(ON_T5_US);
      default: on_us = 22'h0;
    endcase
  endfunction

  function automatic logic [21:0] per_us(input logic [2:0] code);
    case (code)
      3'h0:    per_us = 22'(PER_T0_US);
      3'h1:    per_us = 22'(PER_T1_US);
      3'h2:    per_us = 22'(PER_T2_US);
      3'h3:    per_us = 22'(PER_T3_US);
      3'h4:    per_us = 22'(PER_T4_US);
      3'h5:    per_us = 22'(PER_T5_US);
      3'h6:    per_us = 22'(PER_T6_US);
      default: per_us = 22'(PER_T7_US);
    endcase
  endfunction

  // Register access and clearing
  always_comb begin
    ctrl_d  = ctrl_q;
    rdata_d = rdata_q;
    if (req.rd && req.addr == CTRL_REG_ADDR) begin
      rdata_d = 16'(ctrl_q) & CTRL_REG_WMASK;
    end else if (req.rd) begin
      rdata_d = 16'h0000;
    end
    if (req.wr && req.addr == CTRL_REG_ADDR) begin
      ctrl_d = timer_ctrl_t'(req.wdata & CTRL_REG_WMASK);
    end
    // Other failures do not touch the fields
    if (sense_clear[0]) begin
      ctrl_d.first_on_time_sel = ON_OFF_LOW;
      ctrl_d.first_period_sel  = 3'h0;
    end
    if (sense_clear[1]) begin
      ctrl_d.second_on_time_sel = ON_OFF_LOW;
      ctrl_d.second_period_sel  = 3'h0;
    end
    if (soft_rst || restart_entry) begin
      ctrl_d = timer_ctrl_t'(CTRL_REG_RST);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q  <= timer_ctrl_t'(CTRL_REG_RST);
      rdata_q <= 16'h0000;
    end else begin
      ctrl_q  <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;

  // Shared microsecond tick and one per-timer counter for both period and on-time
  logic [7:0] pre_q;
  logic [7:0] pre_d;
  logic       tick;
  assign tick = (pre_q == 8'(US_CYCLES - 1));

  always_comb begin
    pre_d = tick ? 8'h00 : pre_q + 8'h01;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pre_q <= 8'h00;
    end else begin
      pre_q <= pre_d;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_tmr
      logic [21:0] cnt_q;
      logic [21:0] cnt_d;
      logic        out_q;
      logic        out_d;
      logic        start_q;
      logic        start_d;
      logic        running;
      logic        hold_high;

      assign running   = (on_sel[g] != ON_OFF_LOW) && (on_sel[g] < ON_OFF_HIGH);
      assign hold_high = (on_sel[g] >= ON_OFF_HIGH);

      always_comb begin
        cnt_d   = cnt_q;
        start_d = 1'b0;
        out_d   = 1'b0;
        if (!running) begin
          // Preload so the first tick opens a full period, unless the starting write also selects a longer period
          cnt_d = per_us(per_sel[g]) - 22'h1;
          out_d = hold_high;
        end else if (tick) begin
          if (cnt_q >= per_us(per_sel[g]) - 22'h1) begin
            cnt_d   = 22'h0;
            start_d = 1'b1;
          end else begin
            cnt_d = cnt_q + 22'h1;
          end
          out_d = (cnt_d < on_us(on_sel[g]));
        end else begin
          out_d = out_q;
        end
      end

      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          cnt_q   <= 22'h0;
          out_q   <= 1'b0;
          start_q <= 1'b0;
        end else begin
          cnt_q   <= cnt_d;
          out_q   <= out_d;
          start_q <= start_d;
        end
      end

      assign on_end[g]       = running && out_q && !out_d;
      assign timer_out[g]    = out_q;
      assign period_start[g] = start_q;
    end
  endgenerate

  // Cyclic wake and timer-based wake filter
  logic [1:0] cw_q;
  logic [1:0] cw_d;
  localparam int unsigned FILT_LIMIT = FILT_US * US_CYCLES;
  logic [11:0] filt_q;
  logic [11:0] filt_d;
  logic       wdet_q;
  logic       wdet_d;
  logic       filt_timer;
  logic       filt_end;

  always_comb begin
    cw_d       = 2'b00;
    filt_timer = 1'b0;
    filt_end   = 1'b0;
    if (ctrl_q.cyclic_wake_sel == WAKE_FIRST) begin
      cw_d[0] = on_end[0];
    end else if (ctrl_q.cyclic_wake_sel == WAKE_SECOND) begin
      cw_d[1] = on_end[1];
    end
    // WAKE_NONE and reserved code leave both clear
    if (wake_filter_sel == FILT_CYC_FIRST) begin
      filt_timer = 1'b1;
      filt_end   = on_end[0];
    end else if (wake_filter_sel == FILT_CYC_SECOND) begin
      filt_timer = 1'b1;
      filt_end   = on_end[1];
    end
    // Window of 16 us of steady high input just before on-time ends
    if (!wake_in) begin
      filt_d = 12'h000;
    end else if (filt_q != 12'(FILT_LIMIT)) begin
      filt_d = filt_q + 12'h001;
    end else begin
      filt_d = filt_q;
    end
    wdet_d = filt_timer && filt_end && (filt_q == 12'(FILT_LIMIT));
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cw_q   <= 2'b00;
      filt_q <= 12'h000;
      wdet_q <= 1'b0;
    end else begin
      cw_q   <= cw_d;
      filt_q <= filt_d;
      wdet_q <= wdet_d;
    end
  end

  assign cyc_wake_event = cw_q;
  assign wake_detected  = wdet_q;

endmodule
`default_nettype wire

// file: tb/cyc_timer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cyc_timer_asserts
  import cyc_timer_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        soft_rst,
  input wire logic        restart_entry,
  input wire reg_req_t    req,
  input wire logic [15:0] rdata,
  input wire logic [1:0]  sense_clear,
  input wire logic [1:0]  timer_out,
  input wire logic [1:0]  period_start,
  input wire logic [1:0]  cyc_wake_event
);
  logic [15:0] sh_q;
  logic [15:0] sh_d;
  // Shadow of the control register as the bus should leave it
  always_comb begin
    sh_d = sh_q;
    if (req.wr && req.addr == CTRL_REG_ADDR) sh_d = req.wdata & CTRL_REG_WMASK;
    if (sense_clear[0]) sh_d[6:0] = 7'h00;
    if (sense_clear[1]) sh_d[15:9] = 7'h00;
    if (soft_rst || restart_entry) sh_d = 16'h0000;
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) sh_q <= 16'h0000;
    else sh_q <= sh_d;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_read_back: assert property ($past(req.rd) |-> rdata ==
    ($past(req.addr) == CTRL_REG_ADDR ? $past(sh_q) : 16'h0000)) else $error("read data");
  chk_off_low: assert property (sh_q[6:4] == 3'h0 [*3] |-> !timer_out[0])
    else $error("stopped timer not low");
  chk_off_high: assert property (sh_q[6:4] >= 3'h6 [*3] |-> timer_out[0])
    else $error("stopped timer not high");
  chk_wake_none: assert property (sh_q[8:7] inside {2'h0, 2'h3} [*3]
    |-> cyc_wake_event == 2'h0) else $error("wake without source");
  chk_wake_first: assert property (cyc_wake_event[0] |-> $past(sh_q[8:7]) == 2'h1)
    else $error("first wake unselected");
  chk_wake_second: assert property (cyc_wake_event[1] |-> $past(sh_q[8:7]) == 2'h2)
    else $error("second wake unselected");
  chk_clear_out: assert property (soft_rst || restart_entry
    |-> ##[2:4] timer_out == 2'h0) else $error("output after clear");
  chk_period_high: assert property (period_start[0] |-> ##[0:2] timer_out[0])
    else $error("period start low");
endmodule
bind dual_cyclic_timer_control cyc_timer_asserts u_chk (.ref_clk, .rst, .soft_rst,
  .restart_entry, .req, .rdata, .sense_clear, .timer_out, .period_start, .cyc_wake_event);
`default_nettype wire

// file: tb/tb_dual_cyclic_timer_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dual_cyclic_timer_control
  import cyc_timer_pkg::*;
;
  localparam int unsigned US = 2;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        soft_rst = 1'b0;
  logic        restart_entry = 1'b0;
  reg_req_t    req = '0;
  logic [1:0]  sense_clear = 2'h0;
  logic [2:0]  wake_filter_sel = 3'h0;
  logic        wake_in = 1'b0;
  logic [15:0] rdata;
  logic [15:0] m;
  logic [1:0]  timer_out, period_start, cyc_wake_event;
  logic        wake_detected;
  logic [3:0]  p;
  int          n_mismatch = 0, total_checks = 0, hi, per, wk, det, ps, i;
  int          seed = 32'h16faec4a;
  dual_cyclic_timer_control #(.US_CYCLES(US)) dut (.ref_clk, .rst, .soft_rst,
    .restart_entry, .req, .rdata, .sense_clear, .wake_filter_sel, .wake_in,
    .timer_out, .period_start, .cyc_wake_event, .wake_detected);
  initial forever #2.5 ref_clk = ~ref_clk;
  task automatic print_verdict;
    if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge ref_clk) req <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk) req <= '0;
    if (a == CTRL_REG_ADDR) m = d & CTRL_REG_WMASK;
  endtask
  task automatic rd(input logic [6:0] a);
    @(posedge ref_clk) req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge ref_clk) req <= '0;
    #1 chk(rdata, a == CTRL_REG_ADDR ? m : 16'h0000);
  endtask
  initial begin
    repeat (40000) @(posedge ref_clk);
    n_mismatch++;
    print_verdict;
  end
  initial begin
    m = 16'h0000;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rd(CTRL_REG_ADDR);
    rd(7'h07);
    wr(7'h07, 16'hffff);
    rd(CTRL_REG_ADDR);
    for (i = 0; i < 8; i++) begin
      wr(CTRL_REG_ADDR, 16'($random(seed)));
      rd(CTRL_REG_ADDR);
    end
    // One clear source per pass: soft reset, restart, sense clear of each timer
    for (i = 0; i < 4; i++) begin
      wr(CTRL_REG_ADDR, 16'hffff);
      p = 4'h1 << i;
      @(posedge ref_clk) {sense_clear, restart_entry, soft_rst} <= p;
      @(posedge ref_clk) {sense_clear, restart_entry, soft_rst} <= 4'h0;
      if (p[1:0] != 2'h0) m = 16'h0000;
      if (p[2]) m = m & 16'hff80;
      if (p[3]) m = m & 16'h01ff;
      rd(CTRL_REG_ADDR);
    end
    @(posedge ref_clk);
    wake_filter_sel <= 3'h2;
    wake_in <= 1'b1;
    wr(CTRL_REG_ADDR, 16'h0090);
    // Align on the first period start of the freshly started timer
    for (i = 0; i < 100 && period_start[0] !== 1'b1; i++) @(posedge ref_clk);
    hi = 0;
    per = 0;
    wk = 0;
    det = 0;
    ps = 0;
    // Rise to rise of the first timer output spans one period
    do begin
      @(posedge ref_clk);
      per++;
      hi += int'(timer_out[0] === 1'b1);
      wk += int'(cyc_wake_event[0] === 1'b1);
      det += int'(wake_detected === 1'b1);
      ps += int'(period_start[0] === 1'b1);
    end while ((timer_out[0] !== 1'b1 || per < 300) && per < 30000);
    chk(hi, ON_T1_US * US);
    chk(per, PER_T0_US * US);
    chk(wk, 1);
    chk(det, 1);
    chk(ps, 1);
    wake_filter_sel <= 3'h3;
    wr(CTRL_REG_ADDR, 16'h2110);
    for (i = 0; i < 1000 && cyc_wake_event[1] !== 1'b1; i++) @(posedge ref_clk);
    chk(i < 1000, 1);
    chk(wake_detected, 1'b1);
    chk(timer_out[1], 1'b0);
    print_verdict;
  end
endmodule
`default_nettype wire
